// ---- bench/scrd_asserts.sv ----
// concurrent checks on the link between the controller and the channel end
`timescale 1ns/1ns
module scrd_asserts (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic tx_full_channel_reset_in,
  input wire logic tx_analog_section_reset_in,
  input wire logic tx_user_clocks_stable_in,
  input wire logic tx_reset_complete_out,
  input wire logic rx_full_channel_reset_in,
  input wire logic rx_analog_section_reset_in,
  input wire logic rx_user_clocks_stable_in,
  input wire logic rx_analog_reset_complete_out,
  input wire logic rx_reset_complete_out,
  input wire logic cfg_en,
  input wire logic cfg_rdy
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  // ==========================================================
  // done flags
  chk_tx_done_held: assert property (tx_full_channel_reset_in |-> !tx_reset_complete_out)
    else $error("tx done high during full reset");
  chk_tx_done_ready: assert property ($rose(tx_reset_complete_out) |-> tx_user_clocks_stable_in)
    else $error("tx done rose without user ready");
  chk_tx_done_rise: assert property ($fell(tx_full_channel_reset_in) && tx_user_clocks_stable_in
    |-> ##[1:60] tx_reset_complete_out) else $error("tx done late after full reset");
  chk_rx_done_held: assert property (rx_full_channel_reset_in |-> !rx_reset_complete_out)
    else $error("rx done high during full reset");
  chk_rx_done_ready: assert property ($rose(rx_reset_complete_out) |-> rx_user_clocks_stable_in)
    else $error("rx done rose without user ready");
  chk_rx_ana_low: assert property ($rose(rx_full_channel_reset_in || rx_analog_section_reset_in)
    |-> ##[0:6] !rx_analog_reset_complete_out) else $error("rx analog done not dropped");
  chk_rx_ana_rise: assert property ($fell(rx_analog_section_reset_in)
    |-> ##[1:60] rx_analog_reset_complete_out) else $error("rx analog done late");
  // ==========================================================
  // reset pulse shape and configuration handshake
  chk_tx_pulse_shape: assert property ($rose(tx_analog_section_reset_in)
    |-> tx_analog_section_reset_in[*4] ##1 !tx_analog_section_reset_in)
    else $error("tx analog pulse not four cycles");
  chk_cfg_access: assert property (cfg_en |=> !cfg_en ##1 !cfg_rdy ##1 (cfg_rdy && !cfg_en))
    else $error("config ready not three cycles after enable");
  chk_cfg_rdy_single: assert property (cfg_rdy |=> !cfg_rdy)
    else $error("config ready longer than one cycle");
  cov_cfg: cover property (cfg_en ##3 cfg_rdy);
  cov_tx_done: cover property ($rose(tx_reset_complete_out));
  cov_rx_ana: cover property ($rose(rx_analog_reset_complete_out));
endmodule : scrd_asserts

// ---- bench/serdes_channel_reset_debug_ports_tb.sv ----
// testbench joining controller and channel end through the link interface
`timescale 1ns/1ns
module serdes_channel_reset_debug_ports_tb;
  logic        mclk;
  logic        srst;
  logic [7:0]  req;
  logic [1:0]  rdy;
  logic        cfg_wr;
  logic [8:0]  cfg_addr;
  logic [15:0] cfg_wdata;
  logic [15:0] cfg_rdata;
  logic [3:0]  dn;
  logic [4:0]  busy;
  logic [4:0]  seen;
  logic        cfg_busy;
  logic        hit;
  int          err_total;
  int          total_checks;
  scrd_if lnk ();
  // ==========================================================
  // the two ends and the link checker
  scrd_controller scrd_controller_i (.MCLK(mclk), .SRST(srst), .LNK(lnk.ctl),
    .TX_FULL_REQ(req[0]), .TX_ANALOG_REQ(req[1]), .TX_CODING_REQ(req[2]),
    .TX_READY(rdy[0]), .RX_FULL_REQ(req[3]), .RX_ANALOG_REQ(req[4]),
    .RX_CODING_REQ(req[5]), .RX_BUFFER_REQ(req[6]), .RX_READY(rdy[1]),
    .CFG_REQ(req[7]), .CFG_WRITE(cfg_wr), .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata),
    .CFG_BUSY(cfg_busy), .CFG_DONE(dn[3]), .CFG_RDATA(cfg_rdata), .TX_DONE(dn[0]),
    .RX_DONE(dn[1]), .RX_ANALOG_DONE(dn[2]));
  scrd_device scrd_device_i (.MCLK(mclk), .SRST(srst), .LNK(lnk.dev),
    .TX_ANALOG_BUSY(busy[4]), .TX_CODING_BUSY(busy[3]), .RX_ANALOG_BUSY(busy[2]),
    .RX_CODING_BUSY(busy[1]), .RX_BUFFER_BUSY(busy[0]));
  scrd_asserts scrd_asserts_i (.MCLK(mclk), .SRST(srst),
    .tx_full_channel_reset_in(lnk.tx_full_channel_reset_in),
    .tx_analog_section_reset_in(lnk.tx_analog_section_reset_in),
    .tx_user_clocks_stable_in(lnk.tx_user_clocks_stable_in),
    .tx_reset_complete_out(lnk.tx_reset_complete_out),
    .rx_full_channel_reset_in(lnk.rx_full_channel_reset_in),
    .rx_analog_section_reset_in(lnk.rx_analog_section_reset_in),
    .rx_user_clocks_stable_in(lnk.rx_user_clocks_stable_in),
    .rx_analog_reset_complete_out(lnk.rx_analog_reset_complete_out),
    .rx_reset_complete_out(lnk.rx_reset_complete_out),
    .cfg_en(lnk.cfg_en), .cfg_rdy(lnk.cfg_rdy));
  // ==========================================================
  // shared tasks
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // one-cycle request pulse on a user-side input
  task automatic pulse(input int n);
    @(posedge mclk);
    req[n] <= 1'b1;
    @(posedge mclk);
    req[n] <= 1'b0;
  endtask : pulse
  // collect which sections went busy within a span
  task automatic watch(input int cyc);
    seen = 5'h00;
    repeat (cyc) begin
      @(negedge mclk);
      seen = seen | busy;
    end
  endtask : watch
  task automatic sect(input int n, input logic [4:0] msk, input logic [4:0] exp);
    pulse(n);
    watch(40);
    check("sections busy", {11'h000, exp}, {11'h000, seen & msk});
  endtask : sect
  task automatic wait_flag(input int b, input int lim);
    hit = 1'b0;
    repeat (lim) begin
      @(negedge mclk);
      if (dn[b] === 1'b1) begin
        hit = 1'b1;
        break;
      end
    end
  endtask : wait_flag
  // full reset with ready low: done must wait until ready rises
  task automatic gate(input int n, input int r, input int b);
    @(posedge mclk);
    rdy[r] <= 1'b0;
    pulse(n);
    wait_flag(b, 60);
    check("done before ready", 16'h0000, {15'h0000, hit});
    @(posedge mclk);
    rdy[r] <= 1'b1;
    wait_flag(b, 60);
    check("done after ready", 16'h0001, {15'h0000, hit});
  endtask : gate
  // one configuration access, counting completion pulses
  task automatic cfg_run(input logic wr, input logic [8:0] a, input logic [15:0] d);
    int cnt;
    cnt = 0;
    @(posedge mclk);
    cfg_wr    <= wr;
    cfg_addr  <= a;
    cfg_wdata <= d;
    req[7]    <= 1'b1;
    @(posedge mclk);
    req[7] <= 1'b0;
    @(negedge mclk);
    check("config busy", 16'h0001, {15'h0000, cfg_busy});
    repeat (12) begin
      @(negedge mclk);
      if (dn[3] === 1'b1) cnt++;
    end
    check("config done pulses", 16'h0001, cnt[15:0]);
  endtask : cfg_run
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // ==========================================================
  // clock, watchdog and test sequence
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (4000) @(posedge mclk);
    err_total++;
    wrap_up();
  end
  initial begin
    srst = 1'b1;
    req = 8'h00;
    rdy = 2'h3;
    cfg_wr = 1'b0;
    cfg_addr = 9'h000;
    cfg_wdata = 16'h0000;
    err_total = 0;
    total_checks = 0;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    check("done after reset", 16'h0000, {12'h000, dn});
    sect(1, 5'h1F, 5'h18);
    sect(2, 5'h1F, 5'h08);
    sect(4, 5'h05, 5'h04);
    sect(6, 5'h1F, 5'h01);
    // coding pulse with rx ready low: section stays held until ready rises
    @(posedge mclk);
    rdy[1] <= 1'b0;
    sect(5, 5'h02, 5'h02);
    check("coding held", 16'h0001, {15'h0000, busy[1]});
    @(posedge mclk);
    rdy[1] <= 1'b1;
    watch(40);
    check("coding after ready", 16'h0002, {11'h000, seen & 5'h02});
    check("coding released", 16'h0000, {15'h0000, busy[1]});
    gate(0, 0, 0);
    pulse(0);
    wait_flag(0, 60);
    check("tx done ready high", 16'h0001, {15'h0000, hit});
    gate(3, 1, 1);
    wait_flag(2, 60);
    check("rx analog done", 16'h0001, {15'h0000, hit});
    cfg_run(1'b1, 9'h1A5, 16'hC3A5);
    cfg_run(1'b0, 9'h1A5, 16'h0000);
    check("config read data", 16'hC3A5, cfg_rdata);
    wrap_up();
  end
endmodule : serdes_channel_reset_debug_ports_tb

// ---- inc/scrd_if.sv ----
// interface between the channel reset sequencer and its controller
`timescale 1ns/1ns
interface scrd_if;
  logic        tx_full_channel_reset_in;
  logic        tx_analog_section_reset_in;
  logic        tx_coding_section_reset_in;
  logic        tx_user_clocks_stable_in;
  logic        tx_reset_complete_out;
  logic        rx_full_channel_reset_in;
  logic        rx_analog_section_reset_in;
  logic        rx_coding_section_reset_in;
  logic        rx_elastic_buffer_reset_in;
  logic        rx_user_clocks_stable_in;
  logic        rx_analog_reset_complete_out;
  logic        rx_reset_complete_out;
  logic        cfg_en;
  logic        cfg_we;
  logic [8:0]  cfg_addr;
  logic [15:0] cfg_wdata;
  logic [15:0] cfg_rdata;
  logic        cfg_rdy;
  modport dev (input tx_full_channel_reset_in, tx_analog_section_reset_in,
    tx_coding_section_reset_in, tx_user_clocks_stable_in, rx_full_channel_reset_in,
    rx_analog_section_reset_in, rx_coding_section_reset_in, rx_elastic_buffer_reset_in,
    rx_user_clocks_stable_in, cfg_en, cfg_we, cfg_addr, cfg_wdata,
    output tx_reset_complete_out, rx_analog_reset_complete_out, rx_reset_complete_out,
    cfg_rdata, cfg_rdy);
  modport ctl (output tx_full_channel_reset_in, tx_analog_section_reset_in,
    tx_coding_section_reset_in, tx_user_clocks_stable_in, rx_full_channel_reset_in,
    rx_analog_section_reset_in, rx_coding_section_reset_in, rx_elastic_buffer_reset_in,
    rx_user_clocks_stable_in, cfg_en, cfg_we, cfg_addr, cfg_wdata,
    input tx_reset_complete_out, rx_analog_reset_complete_out, rx_reset_complete_out,
    cfg_rdata, cfg_rdy);
endinterface : scrd_if

// ---- inc/scrd_pkg.sv ----
// types for the channel reset and debug ports; only the channel end uses one, scrd_word_t
package scrd_pkg;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_HOLD, SEQ_RUN, SEQ_DONE} scrd_seq_e;
  typedef logic [15:0] scrd_word_t;
endpackage : scrd_pkg

// ---- inc/scrd_regs.svh ----
// timing counts and widths for the channel reset and debug ports
`ifndef SCRD_REGS_SVH
`define SCRD_REGS_SVH
`define SCRD_CFG_DATA_W      16
`define SCRD_CFG_ADDR_W      9
`define SCRD_TX_ANALOG_CYC   8
`define SCRD_TX_CODING_CYC   4
`define SCRD_RX_ANALOG_CYC   8
`define SCRD_RX_CODING_CYC   4
`define SCRD_RX_BUF_CYC      2
`define SCRD_CFG_LAT_CYC     2
`define SCRD_CNT_W           4
`endif

// ---- logic/scrd_controller.sv ----
// controller end: drives reset pulses and configuration accesses
`timescale 1ns/1ns
`include "scrd_regs.svh"
module scrd_controller (
  input  wire logic        MCLK,
  input  wire logic        SRST,
  scrd_if.ctl              LNK,
  input  wire logic        TX_FULL_REQ,
  input  wire logic        TX_ANALOG_REQ,
  input  wire logic        TX_CODING_REQ,
  input  wire logic        TX_READY,
  input  wire logic        RX_FULL_REQ,
  input  wire logic        RX_ANALOG_REQ,
  input  wire logic        RX_CODING_REQ,
  input  wire logic        RX_BUFFER_REQ,
  input  wire logic        RX_READY,
  input  wire logic        CFG_REQ,
  input  wire logic        CFG_WRITE,
  input  wire logic [8:0]  CFG_ADDR,
  input  wire logic [15:0] CFG_WDATA,
  output      logic        CFG_BUSY,
  output      logic        CFG_DONE,
  output      logic [15:0] CFG_RDATA,
  output      logic        TX_DONE,
  output      logic        RX_DONE,
  output      logic        RX_ANALOG_DONE
);
  // ==========================================================
  // reset pulses: one-cycle request becomes a four-cycle pulse
  // ==========================================================
  localparam int NP = 7;
  logic [NP-1:0] req, pulse_r;
  logic [1:0]    hold_r [NP];
  assign req = {TX_FULL_REQ, TX_ANALOG_REQ, TX_CODING_REQ, RX_FULL_REQ,
                RX_ANALOG_REQ, RX_CODING_REQ, RX_BUFFER_REQ};
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_pulse
      always_ff @(posedge MCLK) begin
        if (SRST) begin
          pulse_r[g] <= 1'b0;
          hold_r[g]  <= 2'h0;
        end else if (req[g] && !pulse_r[g]) begin
          pulse_r[g] <= 1'b1; // high then low
          hold_r[g]  <= 2'h3;
        end else if (hold_r[g] != 2'h0) begin
          hold_r[g] <= hold_r[g] - 2'h1;
        end else begin
          pulse_r[g] <= 1'b0;
        end
      end
    end
  endgenerate
  assign {LNK.tx_full_channel_reset_in, LNK.tx_analog_section_reset_in,
          LNK.tx_coding_section_reset_in, LNK.rx_full_channel_reset_in,
          LNK.rx_analog_section_reset_in, LNK.rx_coding_section_reset_in,
          LNK.rx_elastic_buffer_reset_in} = pulse_r;
  // ready qualifiers pass straight through
  assign LNK.tx_user_clocks_stable_in = TX_READY;
  assign LNK.rx_user_clocks_stable_in = RX_READY;
  assign TX_DONE        = LNK.tx_reset_complete_out;
  assign RX_DONE        = LNK.rx_reset_complete_out;
  assign RX_ANALOG_DONE = LNK.rx_analog_reset_complete_out;
  // ==========================================================
  // configuration access: one enable, wait for ready
  // ==========================================================
  logic        en_r, we_r, busy_r, done_r;
  logic [8:0]  addr_r;
  logic [15:0] wd_r, rd_r;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      en_r   <= 1'b0;
      we_r   <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      addr_r <= 9'h000;
      wd_r   <= 16'h0000;
      rd_r   <= 16'h0000;
    end else begin
      en_r   <= 1'b0;
      done_r <= 1'b0;
      if (CFG_REQ && !busy_r) begin
        en_r   <= 1'b1;
        we_r   <= CFG_WRITE;
        addr_r <= CFG_ADDR;
        wd_r   <= CFG_WDATA;
        busy_r <= 1'b1;
      end else if (busy_r && LNK.cfg_rdy) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
        if (!we_r) rd_r <= LNK.cfg_rdata;
      end
    end
  end
  assign LNK.cfg_en    = en_r;
  assign LNK.cfg_we    = we_r;
  assign LNK.cfg_addr  = addr_r;
  assign LNK.cfg_wdata = wd_r;
  assign CFG_BUSY      = busy_r;
  assign CFG_DONE      = done_r;
  assign CFG_RDATA     = rd_r;
endmodule : scrd_controller

// ---- logic/scrd_device.sv ----
// channel end: reset sequencing, done flags and configuration port
// How it works
// - analog TX pulse resets analog and coding
// - coding TX pulse resets only coding
// - TX done low in reset, needs ready
// - full reset on system clock, done follows
// - RX analog sequence starts on deassertion
// - RX coding sequence waits for user ready
// - buffer pulse resets only elastic buffer
// - RX analog done low during either reset
// - RX analog done only on rich duplex/receive
// - per-channel config port, 16-bit write data
// - RX done low in reset, needs ready
`timescale 1ns/1ns
`include "scrd_regs.svh"
module scrd_device #(
  parameter bit HAS_RX_ANALOG_DONE = 1'b1, // higher-end variant
  parameter bit RX_PATH_PRESENT    = 1'b1  // duplex or receive-only
) (
  input  wire logic MCLK,
  input  wire logic SRST,
  scrd_if.dev       LNK,
  output      logic TX_ANALOG_BUSY,
  output      logic TX_CODING_BUSY,
  output      logic RX_ANALOG_BUSY,
  output      logic RX_CODING_BUSY,
  output      logic RX_BUFFER_BUSY
);
  localparam int CW = `SCRD_CNT_W;
  // ==========================================================
  // input synchronisers: three stages, change once two agree
  // ==========================================================
  localparam int NI = 9;
  logic [NI-1:0] raw_in;
  logic [NI-1:0] s1_r, s2_r, s3_r, cln_r;
  assign raw_in = {LNK.tx_analog_section_reset_in, LNK.tx_coding_section_reset_in,
                   LNK.tx_user_clocks_stable_in, LNK.rx_analog_section_reset_in,
                   LNK.rx_coding_section_reset_in, LNK.rx_elastic_buffer_reset_in,
                   LNK.rx_user_clocks_stable_in, LNK.tx_full_channel_reset_in,
                   LNK.rx_full_channel_reset_in};
  genvar g;
  generate
    for (g = 0; g < NI; g++) begin : g_sync
      always_ff @(posedge MCLK) begin
        if (SRST) begin
          s1_r[g]  <= 1'b0;
          s2_r[g]  <= 1'b0;
          s3_r[g]  <= 1'b0;
          cln_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= raw_in[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g]) begin
            cln_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate
  logic tx_ana, tx_cod, tx_rdy, rx_ana, rx_cod, rx_buf, rx_rdy, tx_full, rx_full;
  assign {tx_ana, tx_cod, tx_rdy, rx_ana, rx_cod, rx_buf, rx_rdy, tx_full, rx_full} = cln_r;
  // falling edges mark the end of each reset pulse
  logic [NI-1:0] prv_r;
  logic [NI-1:0] fall;
  always_ff @(posedge MCLK) begin
    if (SRST) prv_r <= '0;
    else      prv_r <= cln_r;
  end
  assign fall = prv_r & ~cln_r;
  logic tx_ana_fall, tx_cod_fall, rx_ana_fall, rx_cod_fall, rx_buf_fall;
  logic tx_full_fall, rx_full_fall;
  assign tx_ana_fall  = fall[8];
  assign tx_cod_fall  = fall[7];
  assign rx_ana_fall  = fall[5];
  assign rx_cod_fall  = fall[4];
  assign rx_buf_fall  = fall[3];
  assign tx_full_fall = fall[1];
  assign rx_full_fall = fall[0];
  // ==========================================================
  // section reset timers
  // ==========================================================
  logic [CW-1:0] txa_cnt_r, txc_cnt_r, rxa_cnt_r, rxc_cnt_r, rxb_cnt_r;
  logic          rxc_pend_r;
  logic          tx_seq_start, rx_seq_start;
  assign tx_seq_start = tx_ana_fall | tx_full_fall;
  assign rx_seq_start = rx_ana_fall | rx_full_fall;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      txa_cnt_r <= '0;
    end else if (tx_ana | tx_full) begin
      txa_cnt_r <= '0;
    end else if (tx_seq_start) begin
      txa_cnt_r <= CW'(`SCRD_TX_ANALOG_CYC);
    end else if (txa_cnt_r != '0) begin
      txa_cnt_r <= txa_cnt_r - 1'b1;
    end
  end
  // coding timer: restarted by any TX pulse, analog timer only by analog or full reset
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      txc_cnt_r <= '0;
    end else if (tx_seq_start | tx_cod_fall) begin
      txc_cnt_r <= CW'(`SCRD_TX_CODING_CYC);
    end else if (txc_cnt_r != '0 && txa_cnt_r == '0 && !tx_ana && !tx_full) begin
      txc_cnt_r <= txc_cnt_r - 1'b1;
    end
  end
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      rxa_cnt_r <= '0;
    end else if (rx_ana | rx_full) begin
      rxa_cnt_r <= '0;
    end else if (rx_seq_start) begin
      rxa_cnt_r <= CW'(`SCRD_RX_ANALOG_CYC);
    end else if (rxa_cnt_r != '0) begin
      rxa_cnt_r <= rxa_cnt_r - 1'b1;
    end
  end
  // coding pulse is held pending until the user clocks are stable
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      rxc_pend_r <= 1'b0;
      rxc_cnt_r  <= '0;
    end else begin
      if (rx_cod_fall | rx_seq_start) begin
        rxc_pend_r <= 1'b1;
      end else if (rxc_pend_r && rx_rdy && rxa_cnt_r == '0 && !rx_ana) begin
        rxc_pend_r <= 1'b0;
        rxc_cnt_r  <= CW'(`SCRD_RX_CODING_CYC);
      end
      if (!rxc_pend_r && rxc_cnt_r != '0) begin
        rxc_cnt_r <= rxc_cnt_r - 1'b1;
      end
    end
  end
  // buffer timer touches nothing else
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      rxb_cnt_r <= '0;
    end else if (rx_buf_fall) begin
      rxb_cnt_r <= CW'(`SCRD_RX_BUF_CYC);
    end else if (rxb_cnt_r != '0) begin
      rxb_cnt_r <= rxb_cnt_r - 1'b1;
    end
  end
  // section busy levels
  assign TX_ANALOG_BUSY = tx_ana | tx_full | (txa_cnt_r != '0);
  assign TX_CODING_BUSY = TX_ANALOG_BUSY | tx_cod | (txc_cnt_r != '0);
  assign RX_ANALOG_BUSY = rx_ana | rx_full | (rxa_cnt_r != '0);
  assign RX_CODING_BUSY = RX_ANALOG_BUSY | rx_cod | rxc_pend_r | (rxc_cnt_r != '0);
  assign RX_BUFFER_BUSY = rx_buf | (rxb_cnt_r != '0) | rx_full;
  // ==========================================================
  // done flags
  // ==========================================================
  logic tx_done_r, rx_done_r, rx_adone_r;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      tx_done_r  <= 1'b0;
      rx_done_r  <= 1'b0;
      rx_adone_r <= 1'b0;
    end else begin
      tx_done_r  <= !LNK.tx_full_channel_reset_in && !TX_CODING_BUSY && tx_rdy;
      rx_done_r  <= !LNK.rx_full_channel_reset_in && !RX_CODING_BUSY
                    && !RX_BUFFER_BUSY && rx_rdy;
      rx_adone_r <= !LNK.rx_full_channel_reset_in && !RX_ANALOG_BUSY
                    && !LNK.rx_analog_section_reset_in;
    end
  end
  assign LNK.tx_reset_complete_out = tx_done_r & !LNK.tx_full_channel_reset_in;
  assign LNK.rx_reset_complete_out = rx_done_r & !LNK.rx_full_channel_reset_in;
  assign LNK.rx_analog_reset_complete_out = (HAS_RX_ANALOG_DONE && RX_PATH_PRESENT)
                                            ? rx_adone_r : 1'b0;
  // ==========================================================
  // configuration port: word store, ready after fixed latency
  // ==========================================================
  scrd_pkg::scrd_word_t mem_r [0:(1 << `SCRD_CFG_ADDR_W)-1];
  scrd_pkg::scrd_word_t rdata_r;
  logic [1:0]           lat_r;
  logic                 rdy_r;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      lat_r   <= '0;
      rdy_r   <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      rdy_r <= 1'b0;
      if (LNK.cfg_en && lat_r == '0) begin
        lat_r <= 2'(`SCRD_CFG_LAT_CYC);
        if (LNK.cfg_we) mem_r[LNK.cfg_addr] <= LNK.cfg_wdata;
        else            rdata_r <= mem_r[LNK.cfg_addr];
      end else if (lat_r != '0) begin
        lat_r <= lat_r - 1'b1;
        rdy_r <= (lat_r == 2'h1);
      end
    end
  end
  assign LNK.cfg_rdata = rdata_r;
  assign LNK.cfg_rdy   = rdy_r;
endmodule : scrd_device
